// *** lbt_regs.vh ***
// Register map, field positions, reset values and timing for the blend block
`ifndef LBT_REGS_VH
`define LBT_REGS_VH

// ==========================================================================
// Register byte offsets
`define LBT_OFS_CTRL     12'h000
`define LBT_OFS_HTIME    12'h004
`define LBT_OFS_HSYNC    12'h008
`define LBT_OFS_VTIME    12'h00C
`define LBT_OFS_FGPOS    12'h010
`define LBT_OFS_FGSIZE   12'h014
`define LBT_OFS_REPEAT   12'h018
`define LBT_OFS_ALPHA    12'h01C
`define LBT_OFS_LAYERBG  12'h020
`define LBT_OFS_FADE     12'h024
`define LBT_OFS_STATUS   12'h028
`define LBT_OFS_SCREEN   12'h02C

// ==========================================================================
// Control fields
`define LBT_CTRL_EN      0
`define LBT_CTRL_REPEAT  1
`define LBT_CTRL_START   2
`define LBT_CTRL_DIRIN   3
`define LBT_CTRL_MODE    4

// ==========================================================================
// Status fields
`define LBT_STAT_BUSY    0
`define LBT_STAT_UNDER   1
`define LBT_STAT_LVL_LO  8

// ==========================================================================
// Reset values
`define LBT_RST_HTOTAL   11'h140
`define LBT_RST_HACTIVE  11'h0F0
`define LBT_RST_HBP      8'h06
`define LBT_RST_HSW      8'h04
`define LBT_RST_VTOTAL   11'h148
`define LBT_RST_VACTIVE  11'h140
`define LBT_RST_VBP      8'h04
`define LBT_RST_VSW      8'h04
`define LBT_RST_POS      11'h000
`define LBT_RST_FGW      11'h0F0
`define LBT_RST_FGH      11'h140
`define LBT_RST_REPEAT   8'h00
`define LBT_RST_ALPHA    8'hFF
`define LBT_RST_LAYERBG  24'hFFFFFF
`define LBT_RST_FADE     8'h00
`define LBT_RST_SCREEN   24'h000000

`endif

// *** lbt_blend_timing.v ***
// Layer blending, fade and horizontal line timing toward an LCD panel
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "lbt_regs.vh"

module lbt_blend_timing (
    input  wire        clk_sys,
    input  wire        resetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        pixClk,
    input  wire        pairValid,
    input  wire [47:0] pairData,
    output wire        pairReady,
    output reg  [10:0] fgRow,
    output reg         lineSyncN,
    output reg         frameSyncN,
    output reg         dataEnable,
    output reg  [23:0] pixOut
);

// ==========================================================================
// Registers
reg         enable;
reg         repeatEn;
reg         dirIn;
reg         blendMode;
reg  [10:0] hTotal;
reg  [10:0] hActive;
reg  [7:0]  hBackPorch;
reg  [7:0]  hSyncWidth;
reg  [10:0] vTotal;
reg  [10:0] vActive;
reg  [7:0]  vBackPorch;
reg  [7:0]  vSyncWidth;
reg  [10:0] fgX;
reg  [10:0] fgY;
reg  [10:0] fgW;
reg  [10:0] fgH;
reg  [7:0]  repeatTimes;
reg  [7:0]  alpha;
reg  [23:0] layerBg;
reg  [7:0]  fadeFrames;
reg  [23:0] screenColor;
reg         underflow;

reg         fadeBusy;
reg  [7:0]  fadeLevel;
reg  [7:0]  fadeIdx;

wire        wrEn = psel & penable & pwrite;
wire        rdAcc = psel & ~pwrite;
wire        startReq = wrEn && (paddr == `LBT_OFS_CTRL) &&
                       pwdata[`LBT_CTRL_START];
reg         mapped;
reg         underSet;

assign pready  = 1'b1;
assign pslverr = psel & penable & ~mapped;

always @* begin
    case (paddr)
        `LBT_OFS_CTRL, `LBT_OFS_HTIME, `LBT_OFS_HSYNC, `LBT_OFS_VTIME,
        `LBT_OFS_FGPOS, `LBT_OFS_FGSIZE, `LBT_OFS_REPEAT, `LBT_OFS_ALPHA,
        `LBT_OFS_LAYERBG, `LBT_OFS_FADE, `LBT_OFS_STATUS,
        `LBT_OFS_SCREEN: mapped = 1'b1;
        default: mapped = 1'b0;
    endcase
end

always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        enable      <= 1'b0;
        repeatEn    <= 1'b0;
        dirIn       <= 1'b0;
        blendMode   <= 1'b0;
        hTotal      <= `LBT_RST_HTOTAL;
        hActive     <= `LBT_RST_HACTIVE;
        hBackPorch  <= `LBT_RST_HBP;
        hSyncWidth  <= `LBT_RST_HSW;
        vTotal      <= `LBT_RST_VTOTAL;
        vActive     <= `LBT_RST_VACTIVE;
        vBackPorch  <= `LBT_RST_VBP;
        vSyncWidth  <= `LBT_RST_VSW;
        fgX         <= `LBT_RST_POS;
        fgY         <= `LBT_RST_POS;
        fgW         <= `LBT_RST_FGW;
        fgH         <= `LBT_RST_FGH;
        repeatTimes <= `LBT_RST_REPEAT;
        alpha       <= `LBT_RST_ALPHA;
        layerBg     <= `LBT_RST_LAYERBG;
        fadeFrames  <= `LBT_RST_FADE;
        screenColor <= `LBT_RST_SCREEN;
        underflow   <= 1'b0;
    end else begin
        if (wrEn) begin
            case (paddr)
                `LBT_OFS_CTRL: begin
                    enable    <= pwdata[`LBT_CTRL_EN];
                    repeatEn  <= pwdata[`LBT_CTRL_REPEAT];
                    blendMode <= pwdata[`LBT_CTRL_MODE];
                    if (!fadeBusy) begin
                        dirIn <= pwdata[`LBT_CTRL_DIRIN];
                    end
                end
                `LBT_OFS_HTIME: begin
                    hTotal  <= pwdata[10:0];
                    hActive <= pwdata[26:16];
                end
                `LBT_OFS_HSYNC: begin
                    hBackPorch <= pwdata[7:0];
                    hSyncWidth <= pwdata[15:8];
                    vBackPorch <= pwdata[23:16];
                    vSyncWidth <= pwdata[31:24];
                end
                `LBT_OFS_VTIME: begin
                    vTotal  <= pwdata[10:0];
                    vActive <= pwdata[26:16];
                end
                `LBT_OFS_FGPOS: begin
                    fgX <= pwdata[10:0];
                    fgY <= pwdata[26:16];
                end
                `LBT_OFS_FGSIZE: begin
                    fgW <= pwdata[10:0];
                    fgH <= pwdata[26:16];
                end
                `LBT_OFS_REPEAT:  repeatTimes <= pwdata[7:0];
                `LBT_OFS_ALPHA:   alpha       <= pwdata[7:0];
                `LBT_OFS_LAYERBG: layerBg     <= pwdata[23:0];
                `LBT_OFS_FADE:    fadeFrames  <= pwdata[7:0];
                `LBT_OFS_SCREEN:  screenColor <= pwdata[23:0];
                default: ;
            endcase
        end
        // Set wins over write-one clear
        if (underSet) begin
            underflow <= 1'b1;
        end else if (wrEn && paddr == `LBT_OFS_STATUS &&
                     pwdata[`LBT_STAT_UNDER]) begin
            underflow <= 1'b0;
        end
    end
end

always @* begin
    prdata = 32'h00000000;
    if (rdAcc) begin
        case (paddr)
            `LBT_OFS_CTRL:    prdata = {27'h0000000, blendMode, dirIn,
                                        1'b0, repeatEn, enable};
            `LBT_OFS_HTIME:   prdata = {5'h00, hActive, 5'h00, hTotal};
            `LBT_OFS_HSYNC:   prdata = {vSyncWidth, vBackPorch,
                                        hSyncWidth, hBackPorch};
            `LBT_OFS_VTIME:   prdata = {5'h00, vActive, 5'h00, vTotal};
            `LBT_OFS_FGPOS:   prdata = {5'h00, fgY, 5'h00, fgX};
            `LBT_OFS_FGSIZE:  prdata = {5'h00, fgH, 5'h00, fgW};
            `LBT_OFS_REPEAT:  prdata = {24'h000000, repeatTimes};
            `LBT_OFS_ALPHA:   prdata = {24'h000000, alpha};
            `LBT_OFS_LAYERBG: prdata = {8'h00, layerBg};
            `LBT_OFS_FADE:    prdata = {24'h000000, fadeFrames};
            `LBT_OFS_STATUS:  prdata = {16'h0000, fadeLevel, 6'h00,
                                        underflow, fadeBusy};
            `LBT_OFS_SCREEN:  prdata = {8'h00, screenColor};
            default:          prdata = 32'h00000000;
        endcase
    end
end

// ==========================================================================
// Pixel clock edge finder
reg  [2:0]  pixSync;
reg         pixLevel;
wire        pixTick = (pixSync[1] == pixSync[2]) & pixSync[2] & ~pixLevel;

always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        pixSync  <= 3'h0;
        pixLevel <= 1'b0;
    end else begin
        pixSync <= {pixSync[1:0], pixClk};
        if (pixSync[1] == pixSync[2]) begin
            pixLevel <= pixSync[2];
        end
    end
end

// ==========================================================================
// Line and frame counters
reg  [10:0] hCnt;
reg  [10:0] vCnt;
wire        lineEnd  = (hCnt >= hTotal - 11'h001);
wire        frameEnd = lineEnd & (vCnt >= vTotal - 11'h001);
wire        frameTick = pixTick & enable & frameEnd;
wire [11:0] hActEnd = {4'h0, hBackPorch} + {1'b0, hActive};
wire [11:0] vActEnd = {4'h0, vBackPorch} + {1'b0, vActive};
wire        hAct = ({1'b0, hCnt} >= {4'h0, hBackPorch}) &&
                   ({1'b0, hCnt} < hActEnd);
wire        vAct = ({1'b0, vCnt} >= {4'h0, vBackPorch}) &&
                   ({1'b0, vCnt} < vActEnd);
wire        inActive = enable & hAct & vAct;
wire [10:0] px = hCnt - {3'h0, hBackPorch};

always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        hCnt <= 11'h000;
        vCnt <= 11'h000;
    end else if (!enable) begin
        hCnt <= 11'h000;
        vCnt <= 11'h000;
    end else if (pixTick) begin
        if (lineEnd) begin
            hCnt <= 11'h000;
            vCnt <= frameEnd ? 11'h000 : vCnt + 11'h001;
        end else begin
            hCnt <= hCnt + 11'h001;
        end
    end
end

// ==========================================================================
// Foreground row tracking with vertical repeat of all fgH foreground rows
reg  [7:0]  fgCopy;
reg         fgRowsLive;
wire [11:0] fgTop = {4'h0, vBackPorch} + {1'b0, fgY};
wire [11:0] nextLine = frameEnd ? 12'h000 : {1'b0, vCnt} + 12'h001;
wire        rowStart = (nextLine == fgTop) & (fgTop < vActEnd);

always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        fgRow      <= 11'h000;
        fgCopy     <= 8'h00;
        fgRowsLive <= 1'b0;
    end else if (pixTick && lineEnd) begin
        if (rowStart) begin
            fgRow      <= 11'h000;
            fgCopy     <= 8'h00;
            fgRowsLive <= 1'b1;
        end else if (frameEnd) begin
            fgRowsLive <= 1'b0;
        end else if (fgRowsLive) begin
            if (fgRow >= fgH - 11'h001) begin
                fgRow <= 11'h000;
                if (!repeatEn || fgCopy >= repeatTimes) begin
                    fgRowsLive <= 1'b0;
                end else begin
                    fgCopy <= fgCopy + 8'h01;
                end
            end else begin
                fgRow <= fgRow + 11'h001;
            end
        end
    end
end

wire        inFgCol = (px >= fgX) &&
                      ({1'b0, px} < {1'b0, fgX} + {1'b0, fgW});
wire        inFg = fgRowsLive & inFgCol;

// ==========================================================================
// Two-entry pixel pair buffer
reg  [47:0] bufMem [0:1];
reg         wrPtr;
reg         rdPtr;
reg  [1:0]  bufCnt;
wire        bufPush = pairValid & pairReady;
wire        bufPop = pixTick & inActive & (bufCnt != 2'h0);
assign pairReady = (bufCnt != 2'h2);

always @* begin
    underSet = pixTick & inActive & (bufCnt == 2'h0);
end

always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        bufMem[0] <= 48'h000000000000;
        bufMem[1] <= 48'h000000000000;
        wrPtr     <= 1'b0;
        rdPtr     <= 1'b0;
        bufCnt    <= 2'h0;
    end else begin
        if (bufPush) begin
            bufMem[wrPtr] <= pairData;
            wrPtr         <= ~wrPtr;
        end
        if (bufPop) begin
            rdPtr <= ~rdPtr;
        end
        bufCnt <= bufCnt + {1'b0, bufPush} - {1'b0, bufPop};
    end
end

// ==========================================================================
// Fade sequencer with serial divider
reg  [15:0] divRem;
reg  [7:0]  divQuo;
reg  [4:0]  divStep;
reg         divRun;
reg         faded;
wire [7:0]  fadeNum = dirIn ? fadeIdx : fadeFrames - fadeIdx;
wire [16:0] divTrial = {divRem, 1'b0};
wire [8:0]  divDiff = divTrial[16:8] - {1'b0, fadeFrames};

always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        fadeBusy  <= 1'b0;
        fadeIdx   <= 8'h00;
        fadeLevel <= `LBT_RST_ALPHA;
        faded     <= 1'b0;
        divRem    <= 16'h0000;
        divQuo    <= 8'h00;
        divStep   <= 5'h00;
        divRun    <= 1'b0;
    end else begin
        if (startReq && !fadeBusy) begin
            fadeBusy <= 1'b1;
            fadeIdx  <= 8'h00;
            if (fadeFrames == 8'h00) begin
                fadeBusy  <= 1'b0;
                fadeLevel <= pwdata[`LBT_CTRL_DIRIN] ? alpha : 8'h00;
                faded     <= ~pwdata[`LBT_CTRL_DIRIN];
            end else begin
                fadeLevel <= pwdata[`LBT_CTRL_DIRIN] ? 8'h00 : alpha;
            end
        end else if (fadeBusy && frameTick && !divRun) begin
            fadeIdx <= fadeIdx + 8'h01;
            divRun  <= 1'b1;
            divStep <= 5'h00;
            divRem  <= 16'h0000;
            divQuo  <= 8'h00;
        end else if (divRun) begin
            // Level = alpha * fadeNum / fadeFrames, one quotient bit per cycle
            if (divStep == 5'h00) begin
                divRem  <= alpha * fadeNum;
                divStep <= 5'h01;
            end else if (divStep <= 5'h08) begin
                divStep <= divStep + 5'h01;
                divQuo  <= {divQuo[6:0], 1'b0};
                divRem  <= divTrial[15:0];
                if (divTrial[16:8] >= {1'b0, fadeFrames}) begin
                    divRem <= {divDiff[7:0], divTrial[7:0]};
                    divQuo <= {divQuo[6:0], 1'b1};
                end
            end else begin
                divRun    <= 1'b0;
                fadeLevel <= divQuo;
                if (fadeIdx == fadeFrames) begin
                    fadeBusy <= 1'b0;
                    faded    <= ~dirIn;
                end
            end
        end
        if (!fadeBusy && !divRun && !(startReq && fadeFrames == 8'h00)) begin
            fadeLevel <= faded ? 8'h00 : alpha;
        end
    end
end

// ==========================================================================
// Layer select and alpha blend
wire [23:0] fgPix = bufMem[rdPtr][47:24];
wire [23:0] bgPix = bufMem[rdPtr][23:0];
wire [23:0] fgLayer = inFg ? fgPix : layerBg;
wire [23:0] topPix = blendMode ? bgPix : fgLayer;
wire [23:0] lowPix = blendMode ? screenColor : bgPix;
wire [7:0]  effAlpha = fadeLevel;
wire [7:0]  invAlpha = 8'hFF - effAlpha;
wire [23:0] blendPix;

genvar ch;
generate
    for (ch = 0; ch < 3; ch = ch + 1) begin : gBlend
        wire [15:0] mixSum = effAlpha * topPix[8*ch+7:8*ch] +
                             invAlpha * lowPix[8*ch+7:8*ch];
        wire [16:0] mixRnd = {1'b0, mixSum} + 17'h00080 +
                             {9'h000, mixSum[15:8]};
        assign blendPix[8*ch+7:8*ch] = mixRnd[15:8];
    end
endgenerate

// ==========================================================================
// Panel outputs
always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        lineSyncN  <= 1'b1;
        frameSyncN <= 1'b1;
        dataEnable <= 1'b0;
        pixOut     <= 24'h000000;
    end else if (pixTick) begin
        lineSyncN  <= ~(enable && hCnt < {3'h0, hSyncWidth});
        frameSyncN <= ~(enable && vCnt < {3'h0, vSyncWidth});
        dataEnable <= inActive;
        pixOut     <= inActive ? blendPix : 24'h000000;
    end
end

endmodule // lbt_blend_timing

// *** lbt_monitor.sv ***
// Port checker for the blend and line timing block
`timescale 1ns/1ps
module lbt_monitor (
    input wire        clk_sys,
    input wire        resetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        pready,
    input wire        pslverr,
    input wire        pixClk,
    input wire        lineSyncN,
    input wire        frameSyncN,
    input wire        dataEnable,
    input wire [23:0] pixOut
);
    localparam logic [15:0] TICK = 16'h0008;
    logic [15:0] tot, act, hbp, hsw, since;
    logic [2:0]  rise;
    logic        pixQ, seen;
    wire         wrEn = psel & penable & pwrite & pready;
    // ==================================================================
    // Timing copy and counters
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tot   <= 16'h0140;
            act   <= 16'h00F0;
            hbp   <= 16'h0006;
            hsw   <= 16'h0004;
            since <= 16'h0000;
            seen  <= 1'b0;
            rise  <= 3'h7;
            pixQ  <= 1'b0;
        end else begin
            if (wrEn && paddr == 12'h004) begin
                tot <= {5'h00, pwdata[10:0]};
                act <= {5'h00, pwdata[26:16]};
            end
            if (wrEn && paddr == 12'h008) begin
                hbp <= {8'h00, pwdata[7:0]};
                hsw <= {8'h00, pwdata[15:8]};
            end
            pixQ  <= pixClk;
            rise  <= (pixClk && !pixQ) ? 3'h0 :
                     (rise == 3'h7 ? rise : rise + 3'h1);
            seen  <= seen | $fell(lineSyncN);
            since <= $fell(lineSyncN) ? 16'h0001 : since + 16'h0001;
        end
    end
    // ==================================================================
    // Assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    a_pready_high: assert property (pready)
        else $error("pready low");
    a_slverr_map: assert property (psel && penable && paddr > 12'h02C
        |-> pslverr) else $error("unmapped access not refused");
    a_slverr_idle: assert property (!(psel && penable) |-> !pslverr)
        else $error("error flag outside access phase");
    a_pix_blank: assert property (!dataEnable |-> pixOut == 24'h000000)
        else $error("pixel data outside active video");
    a_tick_align: assert property ($changed(lineSyncN) ||
        $changed(dataEnable) |-> rise <= 3'h6)
        else $error("panel output moved away from pixel edge");
    a_sync_de_excl: assert property (!lineSyncN |-> !dataEnable)
        else $error("active video during line sync");
    a_line_total: assert property (seen && $fell(lineSyncN)
        |-> since == tot * TICK) else $error("line length wrong");
    a_sync_width: assert property (seen && $rose(lineSyncN)
        |-> since == hsw * TICK) else $error("sync width wrong");
    a_sync_hold: assert property ($fell(lineSyncN)
        |=> !lineSyncN [*7]) else $error("sync shorter than a pixel");
    a_bp_start: assert property (seen && $rose(dataEnable)
        |-> since == hbp * TICK) else $error("back porch wrong");
    a_act_width: assert property (seen && $fell(dataEnable)
        |-> since == (hbp + act) * TICK) else $error("active width wrong");
    a_vsync_line: assert property ($changed(frameSyncN)
        |-> $fell(lineSyncN)) else $error("frame sync off line start");
endmodule // lbt_monitor

bind lbt_blend_timing lbt_monitor u_mon (
    .clk_sys(clk_sys), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .pixClk(pixClk), .lineSyncN(lineSyncN),
    .frameSyncN(frameSyncN),
    .dataEnable(dataEnable), .pixOut(pixOut)
);

// *** lbt_panel_model.sv ***
// Panel model: makes the pixel clock and measures line timing
`timescale 1ns/1ps
module lbt_panel_model (
    output logic        pixClk,
    input  wire         lineSyncN,
    input  wire         dataEnable,
    input  wire [23:0]  pixOut,
    output logic [15:0] lineLen,
    output logic [15:0] syncLen,
    output logic [15:0] bpLen,
    output logic [15:0] actLen,
    output logic [23:0] lastPix
);
    logic [15:0] cnt = 16'h0000;
    logic        lsQ = 1'b1;
    logic        deQ = 1'b0;
    // ==================================================================
    // Free-running dot clock
    initial begin
        pixClk = 1'b0;
        #3;
        forever #40 pixClk = ~pixClk;
    end
    // Sampled before each edge, so values belong to the last pixel
    always @(posedge pixClk) begin
        cnt <= cnt + 16'h0001;
        if (lsQ && !lineSyncN) begin
            lineLen <= cnt;
            cnt     <= 16'h0001;
        end
        if (!lsQ && lineSyncN)
            syncLen <= cnt;
        if (!deQ && dataEnable)
            bpLen <= cnt;
        if (deQ && !dataEnable)
            actLen <= cnt - bpLen;
        if (dataEnable)
            lastPix <= pixOut;
        lsQ <= lineSyncN;
        deQ <= dataEnable;
    end
endmodule // lbt_panel_model

// *** tb.sv ***
// Testbench of the blend and line timing block
`timescale 1ns/1ps
`include "lbt_regs.vh"
module tb;
    localparam logic [23:0] FG = 24'h123456;
    localparam logic [23:0] BG = 24'hABCDEF;
    logic        clk_sys, resetn, psel, penable, pwrite, pairValid, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd;
    wire  [31:0] prdata;
    wire         pready, pslverr, pixClk, pairReady;
    wire         lineSyncN, frameSyncN, dataEnable;
    wire  [10:0] fgRow;
    wire  [23:0] pixOut, lastPix;
    wire  [15:0] lineLen, syncLen, bpLen, actLen;
    integer      miscompares, n_tests, i;
    integer      cycles = 0;
    logic [31:0] rstVal [12] = '{32'h0, 32'h00F00140, 32'h04040406,
        32'h01400148, 32'h0, 32'h014000F0, 32'h0, 32'hFF, 32'hFFFFFF,
        32'h0, 32'h0, 32'h0};
    logic [7:0]  bA [4] = '{8'hFF, 8'h00, 8'hFF, 8'h00};
    logic [23:0] bE [4] = '{FG, BG, BG, 24'h0000FF};

    lbt_blend_timing DUT (
        .clk_sys(clk_sys), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pixClk(pixClk), .pairValid(pairValid),
        .pairData({FG, BG}), .pairReady(pairReady), .fgRow(fgRow),
        .lineSyncN(lineSyncN), .frameSyncN(frameSyncN),
        .dataEnable(dataEnable), .pixOut(pixOut)
    );
    lbt_panel_model panel (
        .pixClk(pixClk), .lineSyncN(lineSyncN), .dataEnable(dataEnable),
        .pixOut(pixOut), .lineLen(lineLen), .syncLen(syncLen),
        .bpLen(bpLen), .actLen(actLen), .lastPix(lastPix)
    );
    // ==================================================================
    // Tasks
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk_sys);
            penable <= 1'b1;
            @(posedge clk_sys);
            while (pready !== 1'b1) @(posedge clk_sys);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge clk_sys);
        end
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        begin
            n_tests = n_tests + 1;
            if (g !== e) begin
                miscompares = miscompares + 1;
                $display("Error at %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask
    task finish_test;
        begin
            $display("Comparisons %0d mismatches %0d", n_tests, miscompares);
            if (miscompares == 0 && n_tests > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // ==================================================================
    // Clock and timeout
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles = cycles + 1;
        if (cycles == 40000) begin
            miscompares = miscompares + 1;
            finish_test;
        end
    end
    // ==================================================================
    // Main sequence
    initial begin
        {resetn, psel, penable, pwrite, pairValid} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        {miscompares, n_tests} = 64'h0;
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        for (i = 0; i < 12; i = i + 1) begin
            apb({i[9:0], 2'b00}, 1'b0, 32'h0);
            chk(i == 10 ? rd & 32'h3 : rd, rstVal[i]);
        end
        apb(12'h030, 1'b0, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        pairValid <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk({31'h0, pairReady}, 32'h0);
        apb(`LBT_OFS_HTIME, 1'b1, 32'h000A0014);
        apb(`LBT_OFS_HSYNC, 1'b1, 32'h01020406);
        apb(`LBT_OFS_VTIME, 1'b1, 32'h00040008);
        apb(`LBT_OFS_FGSIZE, 1'b1, 32'h07FF07FF);
        apb(`LBT_OFS_SCREEN, 1'b1, 32'h000000FF);
        apb(`LBT_OFS_LAYERBG, 1'b1, 32'h0000FF00);
        apb(`LBT_OFS_CTRL, 1'b1, 32'h1);
        repeat (1400) @(posedge clk_sys);
        chk({16'h0, lineLen}, 32'h14);
        chk({16'h0, syncLen}, 32'h4);
        chk({16'h0, bpLen}, 32'h6);
        chk({16'h0, actLen}, 32'hA);
        for (i = 0; i < 6; i = i + 1) begin
            apb(`LBT_OFS_ALPHA, 1'b1, {24'h0, i < 4 ? bA[i] : 8'hFF});
            apb(`LBT_OFS_CTRL, 1'b1, {27'h0, i == 2 || i == 3, 4'h1});
            apb(`LBT_OFS_FGPOS, 1'b1, i == 4 ? 32'h000007FF :
                i == 5 ? 32'h07FF0000 : 32'h0);
            repeat (1400) @(posedge clk_sys);
            chk({8'h0, lastPix}, {8'h0, i < 4 ? bE[i] : 24'h00FF00});
        end
        apb(`LBT_OFS_FGPOS, 1'b1, 32'h0);
        apb(`LBT_OFS_FGSIZE, 1'b1, 32'h000107FF);
        apb(`LBT_OFS_CTRL, 1'b1, 32'h3);
        for (i = 2; i < 4; i = i + 1) begin
            apb(`LBT_OFS_REPEAT, 1'b1, i);
            repeat (1400) @(posedge clk_sys);
            chk({8'h0, lastPix}, i == 2 ? 32'h00FF00 : {8'h0, FG});
        end
        apb(`LBT_OFS_FGSIZE, 1'b1, 32'h07FF07FF);
        apb(`LBT_OFS_FADE, 1'b1, 32'h2);
        apb(`LBT_OFS_CTRL, 1'b1, 32'h5);
        apb(`LBT_OFS_CTRL, 1'b1, 32'hD);
        apb(`LBT_OFS_CTRL, 1'b0, 32'h0);
        chk(rd, 32'h1);
        repeat (1150) @(posedge clk_sys);
        apb(`LBT_OFS_STATUS, 1'b0, 32'h0);
        chk(rd & 32'h1, 32'h1);
        repeat (1500) @(posedge clk_sys);
        apb(`LBT_OFS_STATUS, 1'b0, 32'h0);
        chk(rd & 32'hFF01, 32'h0);
        repeat (1400) @(posedge clk_sys);
        chk({8'h0, lastPix}, {8'h0, BG});
        apb(`LBT_OFS_CTRL, 1'b1, 32'hD);
        repeat (2700) @(posedge clk_sys);
        apb(`LBT_OFS_STATUS, 1'b0, 32'h0);
        chk(rd & 32'hFF01, 32'hFF00);
        repeat (1400) @(posedge clk_sys);
        chk({8'h0, lastPix}, {8'h0, FG});
        pairValid <= 1'b0;
        repeat (1400) @(posedge clk_sys);
        apb(`LBT_OFS_STATUS, 1'b0, 32'h0);
        chk(rd & 32'h2, 32'h2);
        pairValid <= 1'b1;
        repeat (20) @(posedge clk_sys);
        apb(`LBT_OFS_STATUS, 1'b1, 32'h2);
        apb(`LBT_OFS_STATUS, 1'b0, 32'h0);
        chk(rd & 32'h2, 32'h0);
        finish_test;
    end
endmodule // tb
